/* File: hw/brint_top.sv */
/*
 * Buffer-ready interrupt generation for eight pipes, pipe 0 being
 * the default control pipe, with its register port.
 * Assumes the buffer engine supplies event pulses, pipe levels and
 * buffer status synchronous to CLK_SYS_IN; the serial engine acts
 * on ZLP_REPLY_OUT by answering IN tokens with empty packets.
 */
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
module brint_top (
    input wire logic CLK_SYS_IN,
    input wire logic RST_IN,
    input wire logic [brint_pkg::AW-1:0] ADDR_IN,
    input wire logic [brint_pkg::DW-1:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    input wire brint_pkg::brint_evt_t [brint_pkg::NPIPE-1:0] EVT_IN,
    input wire brint_pkg::brint_cfg_t [brint_pkg::NPIPE-1:0] CFG_IN,
    input wire logic [brint_pkg::NPIPE-1:0] BUFFER_ACCESS_STATUS_IN,
    output logic [brint_pkg::DW-1:0] RDATA_OUT,
    output logic IRQ_OUT,
    output logic [brint_pkg::NPIPE-1:0] ZLP_REPLY_OUT
);
    import brint_pkg::*;

    // ******************************************************
    // Declarations
    // ******************************************************
    logic [NPIPE-1:0] set_v;
    logic [NPIPE-1:0] supp_v;
    logic [NPIPE-1:0] pipe_ready_status_r;
    logic [NPIPE-1:0] pipe_ready_status_nxt;
    logic [NPIPE-1:0] pipe_ready_enable_r;
    logic [NPIPE-1:0] buffer_access_status_r;
    logic global_ready_enable_r;
    logic ready_clear_mode_r;
    logic buffer_ready_summary;
    logic wr_sts;
    logic [NPIPE-1:0] sts_clr;
    logic [DW-1:0] rdata_nxt;

    // ******************************************************
    // Condition decoders, one per pipe
    // ******************************************************
    // Pipe 0 is the control pipe and never reports on transmit
    generate
        for (genvar g = 0; g < NPIPE; g++) begin : g_pipe
            brint_cond #(
                .IS_DCP(g == 0)
            ) u_cond (
                .evt_in(EVT_IN[g]),
                .cfg_in(CFG_IN[g]),
                .set_out(set_v[g]),
                .supp_out(supp_v[g])
            );
        end
    endgenerate

    // ******************************************************
    // Register writes
    // ******************************************************
    // Control bits steering interrupt gating and clear mode
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            global_ready_enable_r <= 1'b0;
            ready_clear_mode_r <= 1'b0;
            pipe_ready_enable_r <= RST_PIPE;
        end else if (WR_IN) begin
            if (ADDR_IN == ADR_IE0) begin
                global_ready_enable_r <= WDATA_IN[BIT_GEN];
            end else if (ADDR_IN == ADR_IE1) begin
                ready_clear_mode_r <= WDATA_IN[BIT_MODE];
            end else if (ADDR_IN == ADR_PEN) begin
                pipe_ready_enable_r <= WDATA_IN[NPIPE-1:0];
            end
        end
    end

    // ******************************************************
    // Pipe ready status
    // ******************************************************
    // Writing 0 clears a bit, writing 1 leaves it; a new event in
    // the clearing cycle wins so it is never lost
    assign wr_sts = WR_IN && (ADDR_IN == ADR_STS);
    assign sts_clr = wr_sts ? ~WDATA_IN[NPIPE-1:0] : RST_PIPE;
    assign pipe_ready_status_nxt =
        (pipe_ready_status_r & ~sts_clr) | set_v;

    // Set regardless of the enables, held until cleared
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            pipe_ready_status_r <= RST_PIPE;
        end else begin
            pipe_ready_status_r <= pipe_ready_status_nxt;
        end
    end

    // Buffer status registered so the summary sees a clean level
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            buffer_access_status_r <= RST_PIPE;
        end else begin
            buffer_access_status_r <= BUFFER_ACCESS_STATUS_IN;
        end
    end

    // ******************************************************
    // Summary bit
    // ******************************************************
    brint_sum u_sum (
        .clk_in(CLK_SYS_IN),
        .rst_in(RST_IN),
        .sts_in(pipe_ready_status_r),
        .set_in(set_v),
        .en_in(pipe_ready_enable_r),
        .buffer_access_status_in(buffer_access_status_r),
        .mode_in(ready_clear_mode_r),
        .sum_out(buffer_ready_summary)
    );

    // ******************************************************
    // Outputs
    // ******************************************************
    // Interrupt only with the global enable; costs one cycle
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            IRQ_OUT <= 1'b0;
        end else begin
            IRQ_OUT <= buffer_ready_summary &
                       global_ready_enable_r;
        end
    end

    // Pipes whose IN tokens get an empty packet and no event
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            ZLP_REPLY_OUT <= RST_PIPE;
        end else begin
            for (int i = 0; i < NPIPE; i++) begin
                ZLP_REPLY_OUT[i] <= supp_v[i] &
                                    !CFG_IN[i].is_rx;
            end
        end
    end

    // ******************************************************
    // Register reads
    // ******************************************************
    // Unmapped addresses and idle cycles return zero
    always_comb begin
        rdata_nxt = RST_DATA;
        if (RD_IN) begin
            if (ADDR_IN == ADR_IE0) begin
                rdata_nxt[BIT_GEN] = global_ready_enable_r;
            end else if (ADDR_IN == ADR_IE1) begin
                rdata_nxt[BIT_MODE] = ready_clear_mode_r;
            end else if (ADDR_IN == ADR_PEN) begin
                rdata_nxt[NPIPE-1:0] = pipe_ready_enable_r;
            end else if (ADDR_IN == ADR_STS) begin
                rdata_nxt[NPIPE-1:0] = pipe_ready_status_r;
            end else if (ADDR_IN == ADR_IST0) begin
                rdata_nxt[BIT_SUM] = buffer_ready_summary;
            end
        end
    end

    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            RDATA_OUT <= RST_DATA;
        end else begin
            RDATA_OUT <= rdata_nxt;
        end
    end

    // ******************************************************
    // Assertions
    // ******************************************************
    default clocking cb @(posedge CLK_SYS_IN);
    endclocking
    default disable iff (RST_IN);

    // Any event lands in its status bit at the next edge
    property p_status_set;
        (set_v != RST_PIPE) |=>
            ((pipe_ready_status_r & $past(set_v)) == $past(set_v));
    endproperty
    a_status_set: assert property (p_status_set)
        else $error("ready event not recorded");

    // Interrupt is the gated summary one cycle late
    property p_irq_gate;
        ##1 (IRQ_OUT == $past(buffer_ready_summary &&
                             global_ready_enable_r));
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt gating wrong");

    // Suppressed bulk IN pipes never flag on transmit
    property p_zlp_silent;
        (set_v & supp_v & ~{CFG_IN[7].is_rx, CFG_IN[6].is_rx,
            CFG_IN[5].is_rx, CFG_IN[4].is_rx, CFG_IN[3].is_rx,
            CFG_IN[2].is_rx, CFG_IN[1].is_rx,
            CFG_IN[0].is_rx}) == RST_PIPE;
    endproperty
    a_zlp_silent: assert property (p_zlp_silent)
        else $error("event raised on zero-size bulk IN pipe");

    // Control pipe receive with short packet must flag
    property p_dcp_rx;
        (CFG_IN[0].is_rx && (EVT_IN[0].short_pkt ||
            EVT_IN[0].buf_full)) |=> pipe_ready_status_r[0];
    endproperty
    a_dcp_rx: assert property (p_dcp_rx)
        else $error("control pipe receive not flagged");

    // Control pipe transmit never produces an event
    property p_dcp_tx;
        !CFG_IN[0].is_rx |-> !set_v[0];
    endproperty
    a_dcp_tx: assert property (p_dcp_tx)
        else $error("control pipe flagged on transmit");

    // Without a status write no set bit can fall
    property p_hold;
        !wr_sts |=> ((pipe_ready_status_r &
            $past(pipe_ready_status_r)) ==
            $past(pipe_ready_status_r));
    endproperty
    a_hold: assert property (p_hold)
        else $error("status bit dropped without a clear");

    // Mode zero: summary follows the enabled status
    property p_sum_mode0;
        !ready_clear_mode_r |=> (buffer_ready_summary ==
            $past(|(pipe_ready_status_r & pipe_ready_enable_r)));
    endproperty
    a_sum_mode0: assert property (p_sum_mode0)
        else $error("summary wrong in clear mode zero");

    // Mode one: summary falls once enabled buffers are clear
    property p_sum_mode1;
        (ready_clear_mode_r && buffer_ready_summary &&
         (buffer_access_status_r & pipe_ready_enable_r) == RST_PIPE &&
         (set_v & pipe_ready_enable_r) == RST_PIPE)
            |=> !buffer_ready_summary;
    endproperty
    a_sum_mode1: assert property (p_sum_mode1)
        else $error("summary held in clear mode one");

    // Read request and its one-cycle answer
    sequence s_rd_sts;
        RD_IN && ADDR_IN == ADR_STS;
    endsequence
    sequence s_rd_ans;
        ##1 (RDATA_OUT[NPIPE-1:0] == $past(pipe_ready_status_r));
    endsequence
    property p_read_sts;
        s_rd_sts |-> s_rd_ans;
    endproperty
    a_read_sts: assert property (p_read_sts)
        else $error("status read returned wrong data");

    // Transfer-end mode: a zero packet always flags
    property p_transfer_end_irq_mode_zlp;
        (CFG_IN[1].is_rx && CFG_IN[1].transfer_end_irq_mode &&
         EVT_IN[1].zlp) |=> pipe_ready_status_r[1];
    endproperty
    a_transfer_end_irq_mode_zlp: assert property (p_transfer_end_irq_mode_zlp)
        else $error("zero packet not flagged in transfer-end mode");
endmodule : brint_top

/* File: hw/brint_pkg.sv */
/*
 * Constants and carriers for the buffer-ready interrupt block.
 * Assumes one 100 MHz clock and a plain register port.
 */
// What this block does
// - Set pipe status; interrupt needs both enables
// - Bulk IN with zero packet size: no event
// - Control pipe receive: short packet or full
// - Single buffer receive: short, full, counter end
// - Double buffer, both awaiting reception: same set
// - Double buffer: read done while both waiting
// - Double buffer: buffer clear while both waiting
// - Transfer-end mode: zero packet or read done
// - Single transmit: direction set or packet sent
// - Transmit: auto or serial clear with pending data
// - Double transmit: fill, valid flag or DMA end
// - Transfer-end mode gives no transmit interrupts
// - Zero packet sets status, gives no data
// - Mode zero: summary clears with enabled status
// - Mode one: summary clears with buffer status
package brint_pkg;
    // ******************************************************
    // Sizes and register map
    // ******************************************************
    localparam int NPIPE = 8;
    localparam int AW = 8;
    localparam int DW = 16;
    localparam logic [AW-1:0] ADR_IE0 = 8'h00;
    localparam logic [AW-1:0] ADR_IE1 = 8'h04;
    localparam logic [AW-1:0] ADR_PEN = 8'h08;
    localparam logic [AW-1:0] ADR_STS = 8'h0C;
    localparam logic [AW-1:0] ADR_IST0 = 8'h10;
    localparam int BIT_GEN = 8;
    localparam int BIT_MODE = 0;
    localparam int BIT_SUM = 8;
    localparam logic [NPIPE-1:0] RST_PIPE = 8'h00;
    localparam logic [DW-1:0] RST_DATA = 16'h0000;
    localparam logic [10:0] MAX_PACKET_SIZE_ZERO = 11'h000;

    // ******************************************************
    // Per-pipe carriers
    // ******************************************************
    // One-cycle events from the buffer and serial engines
    typedef struct packed {
        logic short_pkt;
        logic zlp;
        logic buf_full;
        logic trn_end;
        logic read_done;
        logic rd_short_done;
        logic rd_last_done;
        logic cpu_buffer_clear;
        logic dir_tx_set;
        logic tx_done;
        logic auto_buffer_clear;
        logic serial_side_clear;
        logic buffer_valid_flag;
        logic fill_write;
        logic dma_transfer_end;
    } brint_evt_t;

    // Levels describing pipe setup and buffer state
    typedef struct packed {
        logic is_rx;
        logic double_buffer_select;
        logic transfer_end_irq_mode;
        logic is_bulk_in;
        logic [10:0] max_packet_size;
        logic buf_not_full;
        logic both_rx_wait;
        logic both_rd_wait;
        logic tx_pending;
        logic no_tx_wait;
    } brint_cfg_t;
endpackage : brint_pkg

/* File: hw/brint_cond.sv */
/*
 * Per-pipe decoder of buffer-ready conditions.
 * Assumes events are single-cycle pulses synchronous to the clock.
 */
`timescale 1ns/1ps
module brint_cond #(
    parameter bit IS_DCP = 1'b0
) (
    input wire brint_pkg::brint_evt_t evt_in,
    input wire brint_pkg::brint_cfg_t cfg_in,
    output logic set_out,
    output logic supp_out
);
    import brint_pkg::*;
    logic rx_std;
    logic tx_clr;

    // ******************************************************
    // Condition table
    // ******************************************************
    // Pure combinational; the top registers the result
    always_comb begin
        rx_std = evt_in.short_pkt | evt_in.zlp | evt_in.buf_full |
                 (evt_in.trn_end & cfg_in.buf_not_full);
        tx_clr = (evt_in.auto_buffer_clear |
                  evt_in.serial_side_clear) & cfg_in.tx_pending;
        supp_out = cfg_in.is_bulk_in &&
                   cfg_in.max_packet_size == MAX_PACKET_SIZE_ZERO;
        set_out = 1'b0;
        if (cfg_in.is_rx) begin
            if (IS_DCP) begin
                set_out = evt_in.short_pkt | evt_in.zlp |
                          evt_in.buf_full;
            end else if (cfg_in.transfer_end_irq_mode) begin
                set_out = evt_in.zlp | evt_in.rd_short_done |
                          evt_in.rd_last_done;
            end else if (!cfg_in.double_buffer_select) begin
                set_out = rx_std;
            end else begin
                set_out = (cfg_in.both_rx_wait & rx_std) |
                          (cfg_in.both_rd_wait &
                           (evt_in.read_done |
                            evt_in.cpu_buffer_clear));
            end
        end else if (!IS_DCP && !cfg_in.transfer_end_irq_mode) begin
            if (!cfg_in.double_buffer_select) begin
                set_out = evt_in.dir_tx_set | evt_in.tx_done |
                          tx_clr;
            end else begin
                set_out = evt_in.dir_tx_set | tx_clr |
                          (cfg_in.no_tx_wait &
                           (evt_in.fill_write |
                            evt_in.buffer_valid_flag |
                            evt_in.dma_transfer_end));
            end
            if (supp_out) begin
                set_out = 1'b0;
            end
        end
    end
endmodule : brint_cond

/* File: hw/brint_sum.sv */
/*
 * Buffer-ready summary bit with its two clearing modes.
 * Assumes status, enables and buffer status are registered levels.
 */
`timescale 1ns/1ps
module brint_sum (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [brint_pkg::NPIPE-1:0] sts_in,
    input wire logic [brint_pkg::NPIPE-1:0] set_in,
    input wire logic [brint_pkg::NPIPE-1:0] en_in,
    input wire logic [brint_pkg::NPIPE-1:0] buffer_access_status_in,
    input wire logic mode_in,
    output logic sum_out
);
    import brint_pkg::*;
    logic sum_nxt;

    // Mode one waits on the buffers, so software clears alone
    // never drop the summary there
    always_comb begin
        if (!mode_in) begin
            sum_nxt = |(sts_in & en_in);
        end else begin
            sum_nxt = |(set_in & en_in) |
                      (sum_out & |(buffer_access_status_in & en_in));
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sum_out <= 1'b0;
        end else begin
            sum_out <= sum_nxt;
        end
    end
endmodule : brint_sum

/* File: tb/brint_eng_model.sv */
/*
 * Model of the buffer and serial engines beside the ready block.
 * Assumes the bench asks for one event at a time through fire_in.
 */
`timescale 1ns/1ps
module brint_eng_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic fire_in,
    input wire logic [2:0] pipe_in,
    input wire logic [3:0] kind_in,
    input wire brint_pkg::brint_cfg_t cfg_in,
    input wire logic [brint_pkg::NPIPE-1:0] buffer_access_status_in,
    output brint_pkg::brint_evt_t [brint_pkg::NPIPE-1:0] evt_out,
    output brint_pkg::brint_cfg_t [brint_pkg::NPIPE-1:0] cfg_out,
    output logic [brint_pkg::NPIPE-1:0] buffer_access_status_out
);
    import brint_pkg::*;
    // ******************************************************
    // Event pulses and pipe levels
    // ******************************************************
    // Levels are registered with the pulse so both land together
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            evt_out <= '0;
            cfg_out <= '0;
            buffer_access_status_out <= '0;
        end else begin
            evt_out <= '0; // Events never last beyond one cycle
            if (fire_in) begin
                evt_out[pipe_in] <= brint_evt_t'(15'h0001 << kind_in);
            end
            cfg_out <= {NPIPE{cfg_in}};
            buffer_access_status_out <= buffer_access_status_in;
        end
    end
endmodule : brint_eng_model

/* File: tb/buffer_ready_interrupt_tb.sv */
/*
 * Self-checking bench for the buffer-ready interrupt block.
 * Assumes the register map and latencies of the package and notes.
 */
`timescale 1ns/1ps
module buffer_ready_interrupt_tb;
    import brint_pkg::*;
    // ******************************************************
    // Signals
    // ******************************************************
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [AW-1:0] addr = '0;
    logic [DW-1:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic fire = 1'b0;
    logic [2:0] pipe = '0;
    logic [3:0] kind = '0;
    brint_cfg_t cfg = '0;
    logic [NPIPE-1:0] buffer_access_status = '0;
    brint_evt_t [NPIPE-1:0] evt;
    brint_cfg_t [NPIPE-1:0] cfg_p;
    logic [NPIPE-1:0] buffer_access_status_p;
    logic [DW-1:0] rdata;
    logic irq;
    logic [NPIPE-1:0] zlp;
    int n_fail = 0;
    int comparisons = 0;
    int cyc = 0;
    int seed = 67735;

    always #5 clk = ~clk;

    brint_eng_model ENG (.clk_in(clk), .rst_in(rst), .fire_in(fire),
        .pipe_in(pipe), .kind_in(kind), .cfg_in(cfg), .buffer_access_status_in(buffer_access_status),
        .evt_out(evt), .cfg_out(cfg_p), .buffer_access_status_out(buffer_access_status_p));

    brint_top DUT (.CLK_SYS_IN(clk), .RST_IN(rst), .ADDR_IN(addr),
        .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .EVT_IN(evt),
        .CFG_IN(cfg_p), .BUFFER_ACCESS_STATUS_IN(buffer_access_status_p), .RDATA_OUT(rdata),
        .IRQ_OUT(irq), .ZLP_REPLY_OUT(zlp));

    // ******************************************************
    // Helpers
    // ******************************************************
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish

    // Hang guard: whole run needs well under 5000 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    task automatic chk(input string nm, input logic [DW-1:0] e,
            input logic [DW-1:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic reg_wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : reg_wr

    // Read data stand only in the cycle after the strobe
    task automatic reg_chk(input logic [AW-1:0] a, input logic [DW-1:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("register", e, rdata);
    endtask : reg_chk

    // One event pulse, then room for status, summary and interrupt
    task automatic fire_evt(input int p, input int k);
        @(posedge clk);
        fire <= 1'b1;
        pipe <= 3'(p);
        kind <= 4'(k);
        @(posedge clk);
        fire <= 1'b0;
        repeat (5) @(posedge clk);
    endtask : fire_evt

    // Expected status setting for event index k (0 = last field)
    function automatic logic exp_set(input int p, input int k,
            input brint_cfg_t c);
        brint_evt_t v;
        logic rxc;
        v = brint_evt_t'(15'h0001 << k);
        rxc = v.short_pkt | v.zlp | v.buf_full;
        if (c.is_rx) begin
            if (p == 0)
                return rxc;
            if (c.transfer_end_irq_mode)
                return v.zlp | v.rd_short_done | v.rd_last_done;
            rxc = rxc | (v.trn_end & c.buf_not_full);
            if (!c.double_buffer_select)
                return rxc;
            return (c.both_rx_wait & rxc)
                | (c.both_rd_wait & (v.read_done | v.cpu_buffer_clear));
        end
        if (p == 0 || c.transfer_end_irq_mode)
            return 1'b0;
        if (c.is_bulk_in && c.max_packet_size == MAX_PACKET_SIZE_ZERO)
            return 1'b0;
        return v.dir_tx_set
            | (c.tx_pending & (v.auto_buffer_clear | v.serial_side_clear))
            | (!c.double_buffer_select & v.tx_done)
            | (c.double_buffer_select & c.no_tx_wait & (v.fill_write
            | v.buffer_valid_flag | v.dma_transfer_end));
    endfunction : exp_set

    // ******************************************************
    // Main sequence
    // ******************************************************
    initial begin
        logic [AW-1:0] adrs [6];
        logic [31:0] r;
        brint_cfg_t c;
        int p;
        int k;
        adrs = '{ADR_IE0, ADR_IE1, ADR_PEN, ADR_STS, ADR_IST0, 8'h14};
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        // Reset values, unmapped place reads zero
        foreach (adrs[i]) reg_chk(adrs[i], 16'h0000);
        reg_wr(ADR_IE0, 16'hFFFF);
        reg_chk(ADR_IE0, 16'h0100);
        reg_wr(ADR_IE1, 16'hFFFF);
        reg_chk(ADR_IE1, 16'h0001);
        reg_wr(ADR_PEN, 16'hFFA5);
        reg_chk(ADR_PEN, 16'h00A5);
        reg_wr(ADR_IST0, 16'hFFFF);
        reg_chk(ADR_IST0, 16'h0000);
        reg_wr(8'h14, 16'hFFFF);
        reg_chk(8'h14, 16'h0000);
        // Mode zero: both enables give the interrupt
        reg_wr(ADR_IE1, 16'h0000);
        reg_wr(ADR_PEN, 16'h0008);
        // Whole setup in one assignment so cfg changes once per step
        c = '0;
        c.is_rx = 1'b1;
        cfg <= c;
        fire_evt(3, 14);
        chk("irq", 16'h0001, {15'h0, irq});
        reg_chk(ADR_IST0, 16'h0100);
        reg_wr(ADR_STS, 16'hFFFF);
        reg_chk(ADR_STS, 16'h0008);
        reg_wr(ADR_STS, 16'h0000);
        repeat (4) @(posedge clk);
        chk("irq", 16'h0000, {15'h0, irq});
        reg_chk(ADR_IST0, 16'h0000);
        // Pipe not enabled: status only
        fire_evt(2, 14);
        chk("irq", 16'h0000, {15'h0, irq});
        reg_chk(ADR_STS, 16'h0004);
        reg_wr(ADR_STS, 16'h0000);
        // Global enable off: no interrupt
        reg_wr(ADR_IE0, 16'h0000);
        fire_evt(3, 14);
        chk("irq", 16'h0000, {15'h0, irq});
        reg_wr(ADR_STS, 16'h0000);
        // Mode one: summary follows buffer status
        reg_wr(ADR_IE0, 16'h0100);
        reg_wr(ADR_IE1, 16'h0001);
        buffer_access_status <= 8'h08;
        fire_evt(3, 14);
        chk("irq", 16'h0001, {15'h0, irq});
        reg_wr(ADR_STS, 16'h0000);
        repeat (4) @(posedge clk);
        chk("irq", 16'h0001, {15'h0, irq});
        buffer_access_status <= 8'h00;
        repeat (5) @(posedge clk);
        chk("irq", 16'h0000, {15'h0, irq});
        reg_chk(ADR_IST0, 16'h0000);
        // Random pipes, events and setups
        reg_wr(ADR_PEN, 16'h00FF);
        for (int n = 0; n < 150; n++) begin
            r = $random(seed);
            p = r[2:0];
            k = r[6:3] % 15;
            c = '0;
            c.is_rx = r[7];
            c.double_buffer_select = r[8] & (p != 0);
            c.transfer_end_irq_mode = r[9] & (p != 0);
            c.is_bulk_in = r[10];
            c.max_packet_size = r[11] ? MAX_PACKET_SIZE_ZERO : {r[27:18], 1'b1};
            c.buf_not_full = r[12];
            c.both_rx_wait = r[13];
            c.both_rd_wait = r[14];
            c.tx_pending = r[15];
            c.no_tx_wait = r[16];
            cfg <= c;
            reg_wr(ADR_STS, 16'h0000);
            fire_evt(p, k);
            reg_chk(ADR_STS, 16'(exp_set(p, k, cfg)) << p);
            chk("zlp reply", {8'h0, (cfg.is_bulk_in && !cfg.is_rx
                && cfg.max_packet_size == MAX_PACKET_SIZE_ZERO) ? 7'h7F : 7'h00,
                1'b0}, {8'h0, zlp[7:1], 1'b0});
        end
        tally_and_finish();
    end
endmodule : buffer_ready_interrupt_tb
